//--- rtl/tscr_pkg.sv
package tscr_pkg;
    // resource identifier layout
    localparam logic [7:0]  RID_TAG          = 8'h0B;
    localparam int          RID_NUM_LSB      = 8;
    // register numbers
    localparam logic [7:0]  REG_TILE_CTRL    = 8'h02;
    localparam logic [7:0]  REG_BOOT_STATUS  = 8'h03;
    localparam logic [7:0]  REG_SECURITY     = 8'h05;
    localparam logic [7:0]  REG_ROSC_CTRL    = 8'h06;
    localparam logic [7:0]  REG_ROSC_COUNT0  = 8'h07;
    localparam logic [7:0]  REG_ROSC_COUNT3  = 8'h0A;
    localparam logic [7:0]  REG_RAM_SIZE     = 8'h0C;
    localparam logic [7:0]  REG_DEBUG_SAVED_STATUS_COPY    = 8'h10;
    // writable bits, capture and size masks, reset values
    localparam logic [31:0] CTRL_WMASK       = 32'h03FF_FF36;
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
    localparam logic [31:0] SEC_WMASK        = 32'h8000_5FB1;
    localparam logic [31:0] SEC_RESET        = 32'h0000_0000;
    localparam logic [31:0] ROSC_WMASK       = 32'h0000_0003;
    localparam logic [31:0] ROSC_RESET       = 32'h0000_0000;
    localparam logic [31:0] SSR_WMASK        = 32'h0000_06DF;
    localparam logic [31:0] SSR_CMASK        = 32'h0000_07DF;
    localparam logic [31:0] SSR_RESET        = 32'h0000_0000;
    localparam logic [31:0] RAM_SIZE_MASK    = 32'hFFFF_FFFC;
    // tile control fields
    localparam int          CTRL_DELAY_LSB   = 18;
    localparam int          CTRL_DIV_LSB     = 9;
    localparam int          CTRL_RGMII_EN    = 8;
    localparam int          CTRL_DYNAMIC     = 5;
    localparam int          CTRL_LP_DIV_EN   = 4;
    localparam int          CTRL_UTMI_SEL    = 2;
    localparam int          CTRL_ULPI_EN     = 1;
    // security fields
    localparam int          SEC_WRITE_LOCK   = 31;
    localparam int          SEC_NO_GDEBUG    = 14;
    localparam int          SEC_LOCK_ALL     = 12;
    localparam int          SEC_SECTOR_LSB   = 8;
    localparam int          SEC_OTP_REDUND   = 7;
    localparam int          SEC_OTP_BOOT     = 5;
    localparam int          SEC_NO_JTAG_CFG  = 4;
    localparam int          SEC_NO_JTAG_TAP  = 0;
    // ring oscillator control fields
    localparam int          ROSC_CORE_EN     = 1;
    localparam int          ROSC_PERIPH_EN   = 0;
    // boot status fields
    localparam int          BOOT_PROC_LSB    = 16;
    localparam int          BOOT_OVERRIDE    = 8;
    localparam int          BOOT_CORE1_OFF   = 5;
    localparam int          BOOT_NO_OTP_POLL = 4;
    localparam int          BOOT_FROM_RAM    = 3;
    localparam int          BOOT_FROM_JTAG   = 2;
    // debug saved status fields
    localparam int          SSR_ISSUE_MODE   = 8;
    // sizes
    localparam int          DELAY_W          = 8;
    localparam int          DIV_W            = 9;
    localparam int          ROSC_N           = 4;
    localparam int          ROSC_W           = 16;
    localparam int          SSR_W            = 11;
    localparam logic [31:0] RAM_BYTES_DEF    = 32'h0004_0000;
endpackage

//--- rtl/tscr_regs.sv
// What this block does
// - control bits 25:18 hold transmit delay
// - transmit clock rises at divider, falls at half
// - control bit 8 enables RGMII ports
// - control bit 4 enables low-power divider
// - bit 5 engages divider only when all paused
// - bit 2 selects UTMI, bit 1 enables ULPI
// - boot status reports processor, override, pins
// - boot status shows OTP poll, RAM, JTAG
// - security bit 31 refuses further writes
// - security debug block, OTP locks, redundancy
// - security OTP boot, JTAG blocks
// - security register loads from OTP copy
// - control bits start and stop oscillator groups
// - counters show sixteen bits, rest zero
// - counters survive system reset
// - oscillators asynchronous, usable as randomness
// - RAM size in bytes, bits 31:2
// - debug copy captures saved status word
// - debug copy kernel, handler, enable flags
`timescale 1ns/100ps
`default_nettype none
module tscr_regs #(
    parameter logic [31:0] RAM_BYTES = tscr_pkg::RAM_BYTES_DEF
) (
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    input  wire logic                          ps_valid,
    input  wire logic                          ps_write,
    input  wire logic [15:0]                   ps_rid,
    input  wire logic [31:0]                   ps_wdata,
    output logic                               ps_ack,
    output logic                               ps_fault,
    output logic [31:0]                        ps_rdata,
    input  wire logic                          all_threads_paused,
    input  wire logic [7:0]                    processor_number,
    input  wire logic                          boot_override,
    input  wire logic                          core1_powered_off,
    input  wire logic                          boot_no_otp_poll,
    input  wire logic                          boot_from_ram,
    input  wire logic                          boot_from_jtag,
    input  wire logic [1:0]                    boot_pll_mode_pins,
    input  wire logic                          otp_security_load,
    input  wire logic [31:0]                   otp_security_word,
    input  wire logic [tscr_pkg::ROSC_N-1:0]   ring_osc_in,
    input  wire logic                          debug_entry,
    input  wire logic                          debug_writable_access,
    input  wire logic [tscr_pkg::SSR_W-1:0]    saved_status_word,
    output logic                               rgmii_tx_clk,
    output logic [tscr_pkg::DELAY_W-1:0]       rgmii_tx_delay,
    output logic                               rgmii_port_enable,
    output logic                               low_power_div_engage,
    output logic                               usb_utmi_select,
    output logic                               ulpi_support_enable,
    output logic                               block_global_debug,
    output logic                               otp_lock_all,
    output logic [3:0]                         otp_sector_lock,
    output logic                               otp_redundancy_enable,
    output logic                               force_otp_boot,
    output logic                               block_jtag_config,
    output logic                               block_jtag_tap,
    output logic                               ring_osc_core_enable,
    output logic                               ring_osc_periph_enable
);
    logic [31:0]                      tile_ctrl;
    logic [31:0]                      security_cfg;
    logic [31:0]                      rosc_ctrl;
    logic [31:0]                      debug_saved_status_copy;
    logic [31:0]                      boot_status;
    logic [tscr_pkg::DIV_W-1:0]       div_count;
    logic [1:0]                       pll_s1;
    logic [1:0]                       pll_s2;
    logic [1:0]                       pll_s3;
    logic [1:0]                       pll_mode;
    logic [tscr_pkg::ROSC_N-1:0]      osc_s1;
    logic [tscr_pkg::ROSC_N-1:0]      osc_s2;
    logic [tscr_pkg::ROSC_N-1:0]      osc_s3;
    logic [tscr_pkg::ROSC_N-1:0]      osc_run;
    // zero at power-up only; system reset keeps the count
    logic [tscr_pkg::ROSC_W-1:0]      osc_count [tscr_pkg::ROSC_N] = '{default: 16'h0000};
    logic [7:0]                       reg_num;
    logic                             tag_ok;
    logic                             wr_ctrl;
    logic                             wr_sec;
    logic                             wr_rosc;
    logic                             wr_ssr;
    logic                             mapped;
    logic                             writable;
    logic [31:0]                      next_rdata;
    logic [tscr_pkg::DIV_W-1:0]       div_value;

    assign reg_num   = ps_rid[15:tscr_pkg::RID_NUM_LSB];
    assign tag_ok    = (ps_rid[7:0] == tscr_pkg::RID_TAG);
    assign wr_ctrl   = ps_valid && ps_write && tag_ok && (reg_num == tscr_pkg::REG_TILE_CTRL);
    assign wr_rosc   = ps_valid && ps_write && tag_ok && (reg_num == tscr_pkg::REG_ROSC_CTRL);
    assign wr_sec    = ps_valid && ps_write && tag_ok && (reg_num == tscr_pkg::REG_SECURITY)
                       && !security_cfg[tscr_pkg::SEC_WRITE_LOCK];
    assign wr_ssr    = ps_valid && ps_write && tag_ok && (reg_num == tscr_pkg::REG_DEBUG_SAVED_STATUS_COPY)
                       && debug_writable_access;
    assign div_value = tile_ctrl[tscr_pkg::CTRL_DIV_LSB +: tscr_pkg::DIV_W];

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tile_ctrl <= tscr_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            tile_ctrl <= ps_wdata & tscr_pkg::CTRL_WMASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            security_cfg <= tscr_pkg::SEC_RESET;
        end else if (otp_security_load) begin
            security_cfg <= otp_security_word & tscr_pkg::SEC_WMASK;
        end else if (wr_sec) begin
            security_cfg <= ps_wdata & tscr_pkg::SEC_WMASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rosc_ctrl <= tscr_pkg::ROSC_RESET;
        end else if (wr_rosc) begin
            rosc_ctrl <= ps_wdata & tscr_pkg::ROSC_WMASK;
        end
    end

    // capture on debugger entry; debugger may edit
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            debug_saved_status_copy <= tscr_pkg::SSR_RESET;
        end else if (debug_entry) begin
            debug_saved_status_copy <= {21'h0, saved_status_word} & tscr_pkg::SSR_CMASK;
        end else if (wr_ssr) begin
            // issue mode bit 8 stays read-only
            debug_saved_status_copy <= (ps_wdata & tscr_pkg::SSR_WMASK) | (debug_saved_status_copy & ~tscr_pkg::SSR_WMASK);
        end
    end

    // boot pins are asynchronous; accept once two later stages agree
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pll_s1   <= 2'h0;
            pll_s2   <= 2'h0;
            pll_s3   <= 2'h0;
            pll_mode <= 2'h0;
        end else begin
            pll_s1 <= boot_pll_mode_pins;
            pll_s2 <= pll_s1;
            pll_s3 <= pll_s2;
            if (pll_s2 == pll_s3) begin
                pll_mode <= pll_s3;
            end
        end
    end

    always_comb begin
        boot_status                                = 32'h0;
        boot_status[tscr_pkg::BOOT_PROC_LSB +: 8]  = processor_number;
        boot_status[tscr_pkg::BOOT_OVERRIDE]       = boot_override;
        boot_status[tscr_pkg::BOOT_CORE1_OFF]      = core1_powered_off;
        boot_status[tscr_pkg::BOOT_NO_OTP_POLL]    = boot_no_otp_poll;
        boot_status[tscr_pkg::BOOT_FROM_RAM]       = boot_from_ram;
        boot_status[tscr_pkg::BOOT_FROM_JTAG]      = boot_from_jtag;
        boot_status[1:0]                           = pll_mode;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || !tile_ctrl[tscr_pkg::CTRL_RGMII_EN]) begin
            div_count    <= 9'h000;
            rgmii_tx_clk <= 1'b0;
        end else begin
            div_count <= (div_count >= div_value) ? 9'h000 : div_count + 9'h001;
            // rise wins when value is zero and both compares hit
            if (div_count == div_value) begin
                rgmii_tx_clk <= 1'b1;
            end else if (div_count == (div_value >> 1)) begin
                rgmii_tx_clk <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            low_power_div_engage <= 1'b0;
        end else begin
            low_power_div_engage <= tile_ctrl[tscr_pkg::CTRL_LP_DIV_EN]
                                    && (!tile_ctrl[tscr_pkg::CTRL_DYNAMIC] || all_threads_paused);
        end
    end

    // oscillator edges crossed by three stages
    always_ff @(posedge mclk) begin
        osc_s1 <= ring_osc_in;
        osc_s2 <= osc_s1;
        osc_s3 <= osc_s2;
    end

    assign osc_run = {rosc_ctrl[tscr_pkg::ROSC_PERIPH_EN], rosc_ctrl[tscr_pkg::ROSC_PERIPH_EN],
                      rosc_ctrl[tscr_pkg::ROSC_CORE_EN], rosc_ctrl[tscr_pkg::ROSC_CORE_EN]};

    for (genvar i = 0; i < tscr_pkg::ROSC_N; i++) begin : g_osc
        always_ff @(posedge mclk) begin
            if (osc_run[i] && osc_s2[i] && !osc_s3[i]) begin
                osc_count[i] <= osc_count[i] + 16'h0001;
            end
        end
    end

    assign mapped   = tag_ok && ((reg_num == tscr_pkg::REG_TILE_CTRL)
                      || (reg_num == tscr_pkg::REG_BOOT_STATUS)
                      || (reg_num == tscr_pkg::REG_SECURITY)
                      || (reg_num == tscr_pkg::REG_ROSC_CTRL)
                      || ((reg_num >= tscr_pkg::REG_ROSC_COUNT0)
                          && (reg_num <= tscr_pkg::REG_ROSC_COUNT3))
                      || (reg_num == tscr_pkg::REG_RAM_SIZE)
                      || (reg_num == tscr_pkg::REG_DEBUG_SAVED_STATUS_COPY));
    assign writable = wr_ctrl || wr_sec || wr_rosc || wr_ssr;

    always_comb begin
        next_rdata = 32'h0;
        if (!tag_ok) begin
            next_rdata = 32'h0;
        end else if (reg_num == tscr_pkg::REG_TILE_CTRL) begin
            next_rdata = tile_ctrl;
        end else if (reg_num == tscr_pkg::REG_BOOT_STATUS) begin
            next_rdata = boot_status;
        end else if (reg_num == tscr_pkg::REG_SECURITY) begin
            next_rdata = security_cfg;
        end else if (reg_num == tscr_pkg::REG_ROSC_CTRL) begin
            next_rdata = rosc_ctrl;
        end else if ((reg_num >= tscr_pkg::REG_ROSC_COUNT0)
                     && (reg_num <= tscr_pkg::REG_ROSC_COUNT3)) begin
            next_rdata = {16'h0, osc_count[2'(reg_num - tscr_pkg::REG_ROSC_COUNT0)]};
        end else if (reg_num == tscr_pkg::REG_RAM_SIZE) begin
            // size in bytes, low bits zero
            next_rdata = RAM_BYTES & tscr_pkg::RAM_SIZE_MASK;
        end else if (reg_num == tscr_pkg::REG_DEBUG_SAVED_STATUS_COPY) begin
            next_rdata = debug_saved_status_copy;
        end
    end

    // answer one cycle after each request
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ps_ack   <= 1'b0;
            ps_fault <= 1'b0;
            ps_rdata <= 32'h0;
        end else begin
            ps_ack   <= ps_valid;
            ps_fault <= ps_valid && (!mapped || (ps_write && !writable));
            ps_rdata <= (ps_valid && !ps_write) ? next_rdata : 32'h0;
        end
    end

    assign rgmii_tx_delay         = tile_ctrl[tscr_pkg::CTRL_DELAY_LSB +: tscr_pkg::DELAY_W];
    assign rgmii_port_enable      = tile_ctrl[tscr_pkg::CTRL_RGMII_EN];
    assign usb_utmi_select        = tile_ctrl[tscr_pkg::CTRL_UTMI_SEL];
    assign ulpi_support_enable    = tile_ctrl[tscr_pkg::CTRL_ULPI_EN];
    assign block_global_debug     = security_cfg[tscr_pkg::SEC_NO_GDEBUG];
    assign otp_lock_all           = security_cfg[tscr_pkg::SEC_LOCK_ALL];
    assign otp_sector_lock        = security_cfg[tscr_pkg::SEC_SECTOR_LSB +: 4];
    assign otp_redundancy_enable  = security_cfg[tscr_pkg::SEC_OTP_REDUND];
    assign force_otp_boot         = security_cfg[tscr_pkg::SEC_OTP_BOOT];
    assign block_jtag_config      = security_cfg[tscr_pkg::SEC_NO_JTAG_CFG];
    assign block_jtag_tap         = security_cfg[tscr_pkg::SEC_NO_JTAG_TAP];
    assign ring_osc_core_enable   = rosc_ctrl[tscr_pkg::ROSC_CORE_EN];
    assign ring_osc_periph_enable = rosc_ctrl[tscr_pkg::ROSC_PERIPH_EN];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_ctrl_write;
        ps_valid && ps_write && ps_rid == {tscr_pkg::REG_TILE_CTRL, tscr_pkg::RID_TAG};
    endsequence
    sequence s_ctrl_read;
        ps_valid && !ps_write && ps_rid == {tscr_pkg::REG_TILE_CTRL, tscr_pkg::RID_TAG};
    endsequence

    property p_bad_tag;
        ps_valid && ps_rid[7:0] != tscr_pkg::RID_TAG |=> ps_ack && ps_fault && ps_rdata == 32'h0;
    endproperty
    a_bad_tag: assert property (p_bad_tag) else $error("bad tag not faulted");

    property p_ctrl_roundtrip;
        s_ctrl_write ##1 s_ctrl_read |=> ps_rdata == ($past(ps_wdata, 2) & tscr_pkg::CTRL_WMASK);
    endproperty
    a_ctrl_roundtrip: assert property (p_ctrl_roundtrip)
        else $error("control readback wrong");

    property p_tx_rise;
        rgmii_port_enable && div_count == div_value && $past(rgmii_port_enable)
            |=> rgmii_tx_clk;
    endproperty
    a_tx_rise: assert property (p_tx_rise) else $error("tx clock did not rise");

    property p_tx_fall;
        rgmii_port_enable && div_count != div_value
            && div_count == (div_value >> 1) |=> !rgmii_tx_clk;
    endproperty
    a_tx_fall: assert property (p_tx_fall) else $error("tx clock did not fall");

    property p_tx_off;
        !rgmii_port_enable |=> !rgmii_tx_clk && div_count == 9'h000;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("tx clock runs while disabled");

    property p_lp_static;
        tile_ctrl[tscr_pkg::CTRL_LP_DIV_EN] && !tile_ctrl[tscr_pkg::CTRL_DYNAMIC]
            |=> low_power_div_engage;
    endproperty
    a_lp_static: assert property (p_lp_static) else $error("static divider not engaged");

    property p_lp_dynamic;
        tile_ctrl[tscr_pkg::CTRL_LP_DIV_EN] && tile_ctrl[tscr_pkg::CTRL_DYNAMIC]
            |=> low_power_div_engage == $past(all_threads_paused);
    endproperty
    a_lp_dynamic: assert property (p_lp_dynamic) else $error("dynamic divider wrong");

    property p_sec_locked;
        security_cfg[tscr_pkg::SEC_WRITE_LOCK] && !otp_security_load |=> $stable(security_cfg);
    endproperty
    a_sec_locked: assert property (p_sec_locked) else $error("locked security changed");

    property p_sec_refused;
        ps_valid && ps_write && ps_rid == {tscr_pkg::REG_SECURITY, tscr_pkg::RID_TAG}
            && security_cfg[tscr_pkg::SEC_WRITE_LOCK] |=> ps_ack && ps_fault;
    endproperty
    a_sec_refused: assert property (p_sec_refused) else $error("locked write not refused");

    property p_otp_load;
        otp_security_load |=> security_cfg == ($past(otp_security_word) & tscr_pkg::SEC_WMASK);
    endproperty
    a_otp_load: assert property (p_otp_load) else $error("otp copy not loaded");

    property p_osc_hold;
        !ring_osc_core_enable |=> osc_count[0] == $past(osc_count[0]);
    endproperty
    a_osc_hold: assert property (p_osc_hold) else $error("stopped counter moved");

    property p_ssr_capture;
        debug_entry |=> debug_saved_status_copy == ({21'h0, $past(saved_status_word)} & tscr_pkg::SSR_CMASK);
    endproperty
    a_ssr_capture: assert property (p_ssr_capture) else $error("saved status not captured");

    property p_ssr_guard;
        ps_valid && ps_write && ps_rid == {tscr_pkg::REG_DEBUG_SAVED_STATUS_COPY, tscr_pkg::RID_TAG}
            && !debug_writable_access && !debug_entry |=> ps_fault && $stable(debug_saved_status_copy);
    endproperty
    a_ssr_guard: assert property (p_ssr_guard) else $error("guarded copy written");

    property p_ack_once;
        ps_valid |=> ps_ack
            ##0 (ps_rdata[1:0] == 2'h0 || $past(reg_num) != tscr_pkg::REG_RAM_SIZE);
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("no answer or ram size low bits set");

    property p_ro_write;
        ps_valid && ps_write && ps_rid == {tscr_pkg::REG_BOOT_STATUS, tscr_pkg::RID_TAG}
            |=> ps_ack && ps_fault;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write accepted");
endmodule
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        mclk = 1'b0, rst_n = 1'b0, ps_valid, ps_write, ps_ack, ps_fault;
    logic [15:0] ps_rid;
    logic [31:0] ps_wdata, ps_rdata, b0, b2, a0, a2, otp_security_word = 32'h0;
    logic        all_threads_paused = 1'b0, boot_override = 1'b0, core1_powered_off = 1'b0;
    logic        boot_no_otp_poll = 1'b0, boot_from_ram = 1'b0, boot_from_jtag = 1'b0;
    logic        otp_security_load = 1'b0, debug_entry = 1'b0, debug_writable_access = 1'b0;
    logic [7:0]  processor_number = 8'h00, rgmii_tx_delay;
    logic [1:0]  boot_pll_mode_pins = 2'h0;
    logic [3:0]  ring_osc_in = 4'h0, otp_sector_lock;
    logic [10:0] saved_status_word = 11'h000;
    logic        rgmii_tx_clk, rgmii_port_enable, low_power_div_engage, usb_utmi_select;
    logic        ulpi_support_enable, block_global_debug, otp_lock_all, otp_redundancy_enable;
    logic        force_otp_boot, block_jtag_config, block_jtag_tap, prv, f;
    logic        ring_osc_core_enable, ring_osc_periph_enable;
    int          fails = 0, tests_run = 0, cyc = 0, hi, rs;

    tscr_regs #(.RAM_BYTES(32'h0002_0003)) i_dut (.mclk, .rst_n, .ps_valid, .ps_write,
        .ps_rid, .ps_wdata, .ps_ack, .ps_fault, .ps_rdata, .all_threads_paused,
        .processor_number, .boot_override, .core1_powered_off, .boot_no_otp_poll,
        .boot_from_ram, .boot_from_jtag, .boot_pll_mode_pins, .otp_security_load,
        .otp_security_word, .ring_osc_in, .debug_entry, .debug_writable_access,
        .saved_status_word, .rgmii_tx_clk, .rgmii_tx_delay, .rgmii_port_enable,
        .low_power_div_engage, .usb_utmi_select, .ulpi_support_enable, .block_global_debug,
        .otp_lock_all, .otp_sector_lock, .otp_redundancy_enable, .force_otp_boot,
        .block_jtag_config, .block_jtag_tap, .ring_osc_core_enable, .ring_osc_periph_enable);
    tscr_core_model i_core (.mclk, .ps_valid, .ps_write, .ps_rid, .ps_wdata, .ps_ack,
        .ps_fault, .ps_rdata);

    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic acx(input logic w, input logic [7:0] n, input logic [7:0] t,
                       input logic [31:0] d, input logic ef, output logic [31:0] r);
        i_core.acc(w, n, t, d, r, f);
        chk(32'(f), 32'(ef));
    endtask
    task automatic wr(input logic [7:0] n, input logic [31:0] d, input logic ef);
        acx(1'b1, n, 8'h0B, d, ef, a2);
    endtask
    task automatic rdc(input logic [7:0] n, input logic [31:0] e);
        acx(1'b0, n, 8'h0B, 32'h0, 1'b0, b2);
        chk(b2, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rdc(i == 3 ? 8'h10 : (i == 0 ? 8'h02 : 8'h04 + 8'(i)), 32'h0);
        end
        wr(8'h02, 32'hFFFF_FFFF, 1'b0);
        rdc(8'h02, 32'h03FF_FF36);
        chk(32'({rgmii_tx_delay, rgmii_port_enable, usb_utmi_select, ulpi_support_enable}),
            32'h7FF);
        i_core.wrrd(8'h02, 32'h1234_5678, b2);
        chk(b2, 32'h0234_5630);
        // ratio four: divider field three
        wr(8'h02, 32'h0000_0700, 1'b0);
        tick(20);
        prv = rgmii_tx_clk;
        hi = 0;
        rs = 0;
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk);
            hi += rgmii_tx_clk;
            rs += (rgmii_tx_clk && !prv);
            prv = rgmii_tx_clk;
        end
        chk(hi, 8);
        chk(rs, 4);
        wr(8'h02, 32'h0000_0010, 1'b0);
        tick(2);
        chk(32'(low_power_div_engage), 32'h1);
        wr(8'h02, 32'h0000_0030, 1'b0);
        tick(2);
        chk(32'(low_power_div_engage), 32'h0);
        all_threads_paused <= 1'b1;
        tick(2);
        chk(32'(low_power_div_engage), 32'h1);
        for (int i = 0; i < 2; i++) begin
            processor_number <= i ? 8'h5A : 8'hA5;
            {boot_override, core1_powered_off, boot_from_ram} <= i ? 3'h0 : 3'h7;
            {boot_no_otp_poll, boot_from_jtag} <= i ? 2'h3 : 2'h0;
            boot_pll_mode_pins <= i ? 2'h1 : 2'h2;
            tick(6);
            rdc(8'h03, i ? 32'h005A_0015 : 32'h00A5_012A);
        end
        wr(8'h03, 32'hFFFF_FFFF, 1'b1);
        wr(8'h05, 32'h7FFF_FFFF, 1'b0);
        rdc(8'h05, 32'h0000_5FB1);
        chk(32'({block_global_debug, otp_lock_all, otp_sector_lock, otp_redundancy_enable,
            force_otp_boot, block_jtag_config, block_jtag_tap}), 32'h3FF);
        wr(8'h05, 32'h8000_0001, 1'b0);
        wr(8'h05, 32'h0000_0000, 1'b1);
        rdc(8'h05, 32'h8000_0001);
        otp_security_word <= 32'hFFFF_FFFF;
        otp_security_load <= 1'b1;
        tick(1);
        otp_security_load <= 1'b0;
        rdc(8'h05, 32'h8000_5FB1);
        tick(10);
        acx(1'b0, 8'h07, 8'h0B, 32'h0, 1'b0, b0);
        acx(1'b0, 8'h09, 8'h0B, 32'h0, 1'b0, b2);
        wr(8'h06, 32'h0000_0002, 1'b0);
        chk(32'({ring_osc_core_enable, ring_osc_periph_enable}), 32'h2);
        repeat (5) begin
            ring_osc_in <= 4'hF;
            tick(4);
            ring_osc_in <= 4'h0;
            tick(4);
        end
        tick(4);
        wr(8'h06, 32'h0000_0000, 1'b0);
        // read only after ten stopped cycles
        tick(10);
        acx(1'b0, 8'h07, 8'h0B, 32'h0, 1'b0, a0);
        acx(1'b0, 8'h09, 8'h0B, 32'h0, 1'b0, a2);
        chk(32'(a0[31:16]), 32'h0);
        chk(32'(a0[15:0]), 32'(b0[15:0] + 16'h5));
        chk(a2, b2);
        rdc(8'h08, 32'h0000_0005);
        rdc(8'h0A, 32'h0000_0000);
        rst_n <= 1'b0;
        tick(3);
        rst_n <= 1'b1;
        rdc(8'h07, a0);
        rdc(8'h02, 32'h0);
        wr(8'h10, 32'h0000_07FF, 1'b1);
        debug_writable_access <= 1'b1;
        wr(8'h10, 32'hFFFF_FFFF, 1'b0);
        rdc(8'h10, 32'h0000_06DF);
        saved_status_word <= 11'h7FF;
        debug_entry <= 1'b1;
        tick(1);
        debug_entry <= 1'b0;
        rdc(8'h10, 32'h0000_07DF);
        acx(1'b0, 8'h04, 8'h0B, 32'h0, 1'b1, a0);
        chk(a0, 32'h0);
        acx(1'b0, 8'h02, 8'h0C, 32'h0, 1'b1, a0);
        rdc(8'h0C, 32'h0002_0000);
        wr(8'h0C, 32'h0, 1'b1);
        results();
    end
endmodule
`default_nettype wire

//--- sim/tscr_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module tscr_core_model (
    input  wire logic        mclk,
    output logic             ps_valid,
    output logic             ps_write,
    output logic [15:0]      ps_rid,
    output logic [31:0]      ps_wdata,
    input  wire logic        ps_ack,
    input  wire logic        ps_fault,
    input  wire logic [31:0] ps_rdata
);
    initial begin
        ps_valid = 1'b0;
        ps_write = 1'b0;
        ps_rid = 16'h0000;
        ps_wdata = 32'h0000_0000;
    end
    task automatic acc(input logic wr, input logic [7:0] num, input logic [7:0] tag,
                       input logic [31:0] wd, output logic [31:0] rd, output logic flt);
        int n;
        @(posedge mclk);
        ps_valid <= 1'b1;
        ps_write <= wr;
        ps_rid <= {num, tag};
        ps_wdata <= wd;
        @(posedge mclk);
        // released lines carry junk, not the old value
        ps_valid <= 1'b0;
        ps_rid <= ~{num, tag};
        ps_wdata <= ~wd;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ps_ack !== 1'b1 && n < 4);
        rd = ps_rdata;
        flt = (ps_ack === 1'b1) ? ps_fault : 1'bx;
    endtask
    // back-to-back write then read of one register
    task automatic wrrd(input logic [7:0] num, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge mclk);
        ps_valid <= 1'b1;
        ps_write <= 1'b1;
        ps_rid <= {num, 8'h0B};
        ps_wdata <= wd;
        @(posedge mclk);
        ps_write <= 1'b0;
        @(posedge mclk);
        ps_valid <= 1'b0;
        @(posedge mclk);
        rd = ps_rdata;
    endtask
endmodule
`default_nettype wire
